// [src/spi_select_consts.svh]
// Offsets, field positions, reset values and divider counts of the serial controller
`ifndef SPI_SELECT_CONSTS_SVH
`define SPI_SELECT_CONSTS_SVH
// Register byte offsets
`define OFF_CTRL    4'h0
`define OFF_STATUS  4'h4
`define OFF_DATA    4'h8
`define OFF_PINS    4'hC
// Reset values
`define CTRL_RESET  8'h00
`define PINS_RESET  8'h00
`define BYTE_RESET  8'h00
// Control fields
`define B_IE        7
`define B_EN        6
`define B_LSB       5
`define B_MASTER_SELECT      4
`define B_CLOCK_IDLE_LEVEL      3
`define B_CLOCK_SAMPLE_PHASE      2
// Status fields
`define B_DONE      7
`define B_WRITE_COLLISION_FLAG      6
`define B_DBL       0
// Pin configuration fields
`define B_DIR_MOSI  0
`define B_DIR_MISO  1
`define B_DIR_SCK   2
`define B_DIR_SS    3
`define B_SS_OUT    4
// Half serial period in core clocks (divider ratio / 2)
`define HALF_DIV2   7'h01
`define HALF_DIV4   7'h02
`define HALF_DIV8   7'h04
`define HALF_DIV16  7'h08
`define HALF_DIV32  7'h10
`define HALF_DIV64  7'h20
`define HALF_DIV128 7'h40
// Sixteen clock edges per byte
`define LAST_EDGE   4'hF
`endif

// [src/spi_select_pkg.sv]
// Types shared by the serial controller
package spi_select_pkg;
  typedef enum logic {ST_IDLE, ST_RUN} engine_state_t;
endpackage

// [src/spi_select_and_control.sv]
// Serial peripheral controller with master/slave select handling and AHB-Lite registers
`timescale 1ns/1ps
`include "spi_select_consts.svh"
module spi_select_and_control (
  // System
  input  wire logic        core_clk,
  input  wire logic        reset,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Interrupt
  input  wire logic        globalIrqEnable,
  input  wire logic        irqAck,
  output logic             irqReq,
  // Serial pins
  input  wire logic        sckIn,
  output logic             sckOut,
  output logic             sckOeN,
  input  wire logic        mosiIn,
  output logic             mosiOut,
  output logic             mosiOeN,
  input  wire logic        misoIn,
  output logic             misoOut,
  output logic             misoOeN,
  input  wire logic        ssIn,
  output logic             ssOut,
  output logic             ssOeN
);

  // Half period of the master clock for a rate code
  function automatic logic [6:0] halfCount(input logic dbl, input logic [1:0] rate);
    case ({dbl, rate})
      3'h0:    halfCount = `HALF_DIV4;
      3'h1:    halfCount = `HALF_DIV16;
      3'h2:    halfCount = `HALF_DIV64;
      3'h3:    halfCount = `HALF_DIV128;
      3'h4:    halfCount = `HALF_DIV2;
      3'h5:    halfCount = `HALF_DIV8;
      3'h6:    halfCount = `HALF_DIV32;
      default: halfCount = `HALF_DIV64;
    endcase
  endfunction

  // Bit that leaves the shifter next
  function automatic logic headBit(input logic [7:0] s, input logic lsb);
    headBit = lsb ? s[0] : s[7];
  endfunction

  // Shifter after taking in one sampled bit
  function automatic logic [7:0] shiftIn(input logic [7:0] s, input logic b, input logic lsb);
    shiftIn = lsb ? {b, s[7:1]} : {s[6:0], b};
  endfunction
  // State
  logic [7:0]  ctrl_q, ctrl_d, pins_q, pins_d;
  logic        dbl_q, dbl_d, flag_q, flag_d, write_collision_flag_q, write_collision_flag_d, armed_q, armed_d;
  logic [7:0]  cpu_flags_q, cpu_flags_d, rxBuf_q, rxBuf_d, rxSh_q, rxSh_d;
  logic        outBit_q, outBit_d, sckLvl_q, sckLvl_d;
  logic [3:0]  cnt_q, cnt_d, smp_q, smp_d;
  logic [6:0]  divCnt_q, divCnt_d;
  logic        wrPend_q, wrPend_d, rdPend_q, rdPend_d, mapped_q, mapped_d;
  logic [3:0]  addr_q, addr_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic [3:0]  sync1_q, sync2_q;
  logic        sckPrev_q;
  logic [10:0] runLen_q;
  spi_select_pkg::engine_state_t state_q, state_d;
  // Decoded controls and events
  logic       en, isMaster, lsb, clock_sample_phase, ssHigh, sckSync, mosiSync, misoSync;
  logic [6:0] half;
  logic       fault, slaveActive, mEdge, sEdge, shEdge, sampleEdge, inBit, byteDone;
  logic       dataWr, dataAcc, running, mSample;
  assign en          = ctrl_q[`B_EN];
  assign isMaster    = ctrl_q[`B_MASTER_SELECT];
  assign lsb         = ctrl_q[`B_LSB];
  assign clock_sample_phase        = ctrl_q[`B_CLOCK_SAMPLE_PHASE];
  assign ssHigh      = sync2_q[3];
  assign sckSync     = sync2_q[2];
  assign mosiSync    = sync2_q[1];
  assign misoSync    = sync2_q[0];
  assign half        = halfCount(dbl_q, ctrl_q[1:0]);
  assign running     = (state_q == spi_select_pkg::ST_RUN);
  assign fault       = en & isMaster & ~pins_q[`B_DIR_SS] & ~ssHigh;
  assign slaveActive = en & ~isMaster & ~ssHigh;
  assign mEdge       = en & isMaster & running & (divCnt_q == half - 7'h01);
  assign sEdge       = slaveActive & (sckSync != sckPrev_q);
  assign shEdge      = isMaster ? mEdge : sEdge;
  assign sampleEdge  = ~cnt_q[0] ^ clock_sample_phase;
  assign inBit       = isMaster ? misoSync : mosiSync;
  assign byteDone    = shEdge & (cnt_q == `LAST_EDGE);
  assign dataWr      = wrPend_q & mapped_q & (addr_q == `OFF_DATA);
  assign dataAcc     = (wrPend_q | rdPend_q) & mapped_q & (addr_q == `OFF_DATA);
  assign mSample     = mEdge & sampleEdge;
  // Next state of bus slave, registers and shift engine
  always_comb begin
    ctrl_d   = ctrl_q;
    pins_d   = pins_q;
    dbl_d    = dbl_q;
    flag_d   = flag_q;
    write_collision_flag_d   = write_collision_flag_q;
    armed_d  = armed_q;
    cpu_flags_d   = cpu_flags_q;
    rxBuf_d  = rxBuf_q;
    rxSh_d   = rxSh_q;
    smp_d    = {smp_q[1:0], mSample & ((cnt_q | 4'h1) == `LAST_EDGE), mSample};
    outBit_d = outBit_q;
    sckLvl_d = sckLvl_q;
    cnt_d    = cnt_q;
    divCnt_d = divCnt_q;
    state_d  = state_q;
    hrdata_d = hrdata_q;
    // Master divider
    if (running && isMaster) begin
      divCnt_d = mEdge ? 7'h00 : divCnt_q + 7'h01;
    end
    // Idle: clock rests at its idle level, first bit presented
    if (!running) begin
      sckLvl_d = ctrl_q[`B_CLOCK_IDLE_LEVEL];
      outBit_d = headBit(cpu_flags_q, lsb);
    end
    // One serial clock edge
    if (shEdge) begin
      state_d = spi_select_pkg::ST_RUN;
      cnt_d   = cnt_q + 4'h1;
      if (sampleEdge) begin
        cpu_flags_d = shiftIn(cpu_flags_q, inBit, lsb);
      end else begin
        outBit_d = headBit(cpu_flags_q, lsb);
      end
      if (isMaster) begin
        sckLvl_d = ~sckLvl_q;
      end
      if (byteDone) begin
        state_d = spi_select_pkg::ST_IDLE;
        if (!isMaster) rxBuf_d = cpu_flags_d;
      end
    end
    if (smp_q[2]) rxSh_d = shiftIn(rxSh_q, misoSync, lsb);
    if (smp_q[3]) rxBuf_d = rxSh_d;
    // Engine reset: disabled, slave deselected, or master fall-back
    if (!en || (!isMaster && ssHigh) || fault) begin
      state_d  = spi_select_pkg::ST_IDLE;
      cnt_d    = 4'h0;
      divCnt_d = 7'h00;
    end
    // Data register write loads the single transmit buffer
    if (dataWr && !running) begin
      cpu_flags_d   = hwdata[7:0];
      outBit_d = headBit(hwdata[7:0], lsb);
      if (en && isMaster) begin
        state_d  = spi_select_pkg::ST_RUN;
        cnt_d    = 4'h0;
        divCnt_d = 7'h00;
      end
    end
    // Register writes
    if (wrPend_q && mapped_q) begin
      case (addr_q)
        `OFF_CTRL:   ctrl_d = hwdata[7:0];
        `OFF_STATUS: dbl_d  = hwdata[`B_DBL];
        `OFF_PINS:   pins_d = hwdata[7:0];
        default:     ;
      endcase
    end
    if (fault) begin
      ctrl_d[`B_MASTER_SELECT] = 1'h0;
    end
    // Flags: clears first, hardware sets win
    if (rdPend_q && mapped_q && addr_q == `OFF_STATUS && (flag_q || write_collision_flag_q)) begin
      armed_d = 1'h1;
    end
    if (dataAcc && armed_q) begin
      flag_d  = 1'h0;
      write_collision_flag_d  = 1'h0;
      armed_d = 1'h0;
    end
    if (irqAck) begin
      flag_d = 1'h0;
    end
    if (byteDone || fault) begin
      flag_d = 1'h1;
    end
    if (dataWr && running) begin
      write_collision_flag_d = 1'h1;
    end
    // Read data captured in the wait cycle
    if (rdPend_q) begin
      hrdata_d = 32'h0000_0000;
      if (mapped_q) begin
        case (addr_q)
          `OFF_CTRL:   hrdata_d[7:0] = ctrl_q;
          `OFF_STATUS: hrdata_d[7:0] = {flag_q, write_collision_flag_q, 5'h00, dbl_q};
          `OFF_DATA:   hrdata_d[7:0] = rxBuf_q;
          `OFF_PINS:   hrdata_d[7:0] = pins_q;
          default:     ;
        endcase
      end
    end
  end
  // Address phase capture
  always_comb begin
    wrPend_d = hsel & htrans[1] & hready & hwrite;
    rdPend_d = hsel & htrans[1] & hready & ~hwrite;
    addr_d   = haddr[3:0];
    mapped_d = (haddr[31:4] == 28'h000_0000) & (haddr[1:0] == 2'h0);
  end
  // Registers and pin synchronisers
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ctrl_q    <= `CTRL_RESET;
      pins_q    <= `PINS_RESET;
      dbl_q     <= 1'h0;
      flag_q    <= 1'h0;
      write_collision_flag_q    <= 1'h0;
      armed_q   <= 1'h0;
      cpu_flags_q    <= `BYTE_RESET;
      rxBuf_q   <= `BYTE_RESET;
      rxSh_q    <= `BYTE_RESET;
      outBit_q  <= 1'h0;
      sckLvl_q  <= 1'h0;
      cnt_q     <= 4'h0;
      divCnt_q  <= 7'h00;
      state_q   <= spi_select_pkg::ST_IDLE;
      wrPend_q  <= 1'h0;
      rdPend_q  <= 1'h0;
      mapped_q  <= 1'h0;
      addr_q    <= 4'h0;
      hrdata_q  <= 32'h0000_0000;
      sync1_q   <= 4'hF;
      sync2_q   <= 4'hF;
      sckPrev_q <= 1'h0;
      runLen_q  <= 11'h000;
      smp_q     <= 4'h0;
    end else begin
      ctrl_q    <= ctrl_d;
      pins_q    <= pins_d;
      dbl_q     <= dbl_d;
      flag_q    <= flag_d;
      write_collision_flag_q    <= write_collision_flag_d;
      armed_q   <= armed_d;
      cpu_flags_q    <= cpu_flags_d;
      rxBuf_q   <= rxBuf_d;
      rxSh_q    <= rxSh_d;
      outBit_q  <= outBit_d;
      sckLvl_q  <= sckLvl_d;
      cnt_q     <= cnt_d;
      divCnt_q  <= divCnt_d;
      state_q   <= state_d;
      wrPend_q  <= wrPend_d;
      rdPend_q  <= rdPend_d;
      mapped_q  <= mapped_d;
      addr_q    <= addr_d;
      hrdata_q  <= hrdata_d;
      sync1_q   <= {ssIn, sckIn, mosiIn, misoIn};
      sync2_q   <= sync1_q;
      sckPrev_q <= sckSync;
      runLen_q  <= (running && isMaster) ? runLen_q + 11'h001 : 11'h000;
      smp_q     <= smp_d;
    end
  end
  // Bus answers: reads take one wait cycle, always OKAY
  assign hreadyout = ~rdPend_q;
  assign hresp     = 1'h0;
  assign hrdata    = hrdata_q;
  // Interrupt request
  assign irqReq = ctrl_q[`B_IE] & flag_q & globalIrqEnable;
  // Pin drivers; enable low means driving
  assign sckOut  = sckLvl_q;
  assign mosiOut = outBit_q;
  assign misoOut = outBit_q;
  assign ssOut   = pins_q[`B_SS_OUT];
  assign sckOeN  = ~(pins_q[`B_DIR_SCK] & ~(en & ~isMaster));
  assign mosiOeN = ~(pins_q[`B_DIR_MOSI] & ~(en & ~isMaster));
  assign misoOeN = ~(pins_q[`B_DIR_MISO] & ~(en & (isMaster | ssHigh)));
  assign ssOeN   = ~(pins_q[`B_DIR_SS] & ~(en & ~isMaster));
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence faultSeen;
    en && isMaster && !pins_q[`B_DIR_SS] && !ssHigh;
  endsequence

  a_fault_fallback: assert property (faultSeen |=> !ctrl_q[`B_MASTER_SELECT] && flag_q)
    else $error("fall-back did not clear master bit or set done flag");
  a_ss_input: assert property (en && !isMaster |-> ssOeN)
    else $error("select pin driven in slave role");
  a_slave_passive: assert property (en && !isMaster && ssHigh |-> misoOeN && mosiOeN && sckOeN)
    else $error("deselected slave drives a pin");
  a_ss_reset: assert property (en && !isMaster && ssHigh |=> cnt_q == 4'h0 && !running)
    else $error("slave engine not reset on deselect");
  a_sck_idle: assert property (!running ##1 !running |-> sckLvl_q == $past(ctrl_q[`B_CLOCK_IDLE_LEVEL]))
    else $error("master clock not at idle level");
  a_byte_length: assert property ($past(byteDone) && $past(isMaster) |-> runLen_q == {half, 4'h0})
    else $error("master byte length wrong for rate");
  a_done_capture: assert property (byteDone |=> flag_q && ($past(isMaster) ||
    rxBuf_q == $past(cpu_flags_d)))
    else $error("completed byte not captured");
  a_master_rx: assert property (smp_q[3] |=> rxBuf_q == $past(rxSh_d))
    else $error("completed byte not captured");
  a_write_collision_flag_set: assert property (dataWr && running |=> write_collision_flag_q)
    else $error("collision flag not set");
  a_disabled_quiet: assert property (!en |=> !running)
    else $error("engine runs while disabled");
  a_irq_gate: assert property (irqReq |-> ctrl_q[`B_IE] && flag_q && globalIrqEnable)
    else $error("interrupt without enable or flag");

endmodule

// [test/spi_peer_model.sv]
// Behavioural serial slave on the far side of the controller
`timescale 1ns/1ps
module spi_peer_model (
  // Serial pins
  input  wire logic       sck,
  input  wire logic       ssN,
  input  wire logic       mosi,
  output logic            miso,
  // Mode and data
  input  wire logic       clock_idle_level,
  input  wire logic       clock_sample_phase,
  input  wire logic       lsbFirst,
  input  wire logic [7:0] txByte,
  output logic [7:0]      rxByte,
  output logic            done
);
  int k;
  initial begin
    miso = 1'b0;
    done = 1'b0;
  end
  // Bit of the outgoing byte for slot n
  function automatic logic pick(input int n);
    return lsbFirst ? txByte[n] : txByte[7 - n];
  endfunction
  // Select frames a byte; a released line shows the inverse of its last level
  always @(ssN) begin
    k = 0;
    if (ssN === 1'b0) begin
      done = 1'b0;
      if (!clock_sample_phase) miso = pick(0);
    end else begin
      miso = ~miso;
    end
  end
  // Sample on one edge kind, set up on the other
  always @(sck) begin
    if (ssN === 1'b0 && k < 8) begin
      if ((sck !== clock_idle_level) ^ clock_sample_phase) begin
        rxByte[lsbFirst ? k : 7 - k] = mosi;
        k = k + 1;
        done = (k == 8);
      end else begin
        miso = pick(k);
      end
    end
  end
endmodule

// [test/tb.sv]
// Self-checking bench for the serial controller over AHB-Lite
`timescale 1ns/1ps
`include "spi_select_consts.svh"
module tb;
  logic        core_clk, reset, hsel, hwrite, hreadyout, hresp, irqReq;
  logic        globalIrqEnable, irqAck, tbSs, peerMiso, pCpol, pCpha, pLsb;
  logic        peerDone, rdChk, idleLvl, cntClr;
  logic        sckOut, sckOeN, mosiOut, mosiOeN, misoOut, misoOeN, ssOut, ssOeN;
  logic [31:0] haddr, hwdata, hrdata, rdVal, seedVal;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  pTx, pRx;
  int          num_errors, num_checks, actCnt, n;
  int          ratioTab[8] = '{4, 16, 64, 128, 2, 8, 32, 64};
  logic [31:0] expQ[$];
  logic [7:0]  expPeer[$];
  wire logic   sckW = sckOeN ? 1'b0 : sckOut;
  wire logic   mosiW = mosiOeN ? 1'b0 : mosiOut;
  wire logic   misoW = misoOeN ? peerMiso : misoOut;
  wire logic   ssW = ssOeN ? tbSs : ssOut;

  spi_select_and_control dut_u (.core_clk(core_clk), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
    .globalIrqEnable(globalIrqEnable), .irqAck(irqAck), .irqReq(irqReq),
    .sckIn(sckW), .sckOut(sckOut), .sckOeN(sckOeN), .mosiIn(mosiW), .mosiOut(mosiOut),
    .mosiOeN(mosiOeN), .misoIn(misoW), .misoOut(misoOut), .misoOeN(misoOeN),
    .ssIn(ssW), .ssOut(ssOut), .ssOeN(ssOeN));
  spi_peer_model peer_u (.sck(sckW), .ssN(ssW), .mosi(mosiW), .miso(peerMiso),
    .clock_idle_level(pCpol), .clock_sample_phase(pCpha), .lsbFirst(pLsb), .txByte(pTx), .rxByte(pRx),
    .done(peerDone));

  // Clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // Cycles the serial clock spends away from its idle level
  always @(posedge core_clk) actCnt <= cntClr ? 0 : actCnt + int'(sckOut !== idleLvl);
  // Result watchers take the oldest note off their queue
  always @(posedge core_clk) begin
    if (rdChk === 1'b1 && hreadyout === 1'b1) check("hrdata", expQ.pop_front(), hrdata);
  end
  always @(posedge peerDone) check("peer rx", {24'h0, expPeer.pop_front()}, {24'h0, pRx});

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report();
    $display("Checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One single AHB-Lite transfer; a read may note its expected word
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic chk);
    int c;
    c = 0;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do begin @(posedge core_clk); c++; end while (hreadyout !== 1'b1 && c < 100);
    htrans <= 2'h0;
    hwdata <= d;
    rdChk <= chk;
    if (chk) expQ.push_back(d);
    do begin @(posedge core_clk); c++; end while (hreadyout !== 1'b1 && c < 100);
    rdVal = hrdata;
    rdChk <= 1'b0;
    if (c >= 100) begin num_errors++; final_report(); end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, 1'b0);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    ahb(1'b0, a, e, 1'b1);
  endtask

  initial begin
    reset = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; globalIrqEnable = 1'b0; irqAck = 1'b0;
    tbSs = 1'b1;
    pCpol = 1'b0; pCpha = 1'b0; pLsb = 1'b0; pTx = 8'h0; rdChk = 1'b0;
    idleLvl = 1'b0; cntClr = 1'b1; num_errors = 0; num_checks = 0;
    seedVal = $urandom(98);
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    rd(32'(`OFF_CTRL), {24'h0, `CTRL_RESET});
    rd(32'h10, 32'h0);
    wr(32'(`OFF_PINS), 32'h1D);
    // Every rate code at both speeds, all four clock modes, both bit orders
    for (int i = 0; i < 8; i++) begin
      logic [7:0] tx;
      tx = 8'($urandom);
      pCpol <= i[1] ^ i[2]; pCpha <= i[0] ^ i[2]; pLsb <= i[0] ^ i[1];
      pTx <= 8'($urandom);
      idleLvl <= i[1] ^ i[2];
      wr(32'(`OFF_STATUS), {31'h0, i[2]});
      wr(32'(`OFF_CTRL), {26'h1, i[0] ^ i[1], 1'b1, i[1] ^ i[2], i[0] ^ i[2], 2'(i)});
      wr(32'(`OFF_PINS), 32'h0D);
      cntClr <= 1'b0;
      expPeer.push_back(tx);
      wr(32'(`OFF_DATA), {24'h0, tx});
      if (i == 3) wr(32'(`OFF_DATA), {24'h0, ~tx});
      n = 0;
      do begin
        ahb(1'b0, 32'(`OFF_STATUS), 32'h0, 1'b0); n++;
      end while (rdVal[7] !== 1'b1 && n < 500);
      expQ.delete();
      if (n >= 500) begin num_errors++; final_report(); end
      check("sck cycles", 32'(ratioTab[i] * 4), 32'(actCnt));
      rd(32'(`OFF_STATUS), {24'h0, 1'b1, i == 3, 5'h0, i[2]});
      rd(32'(`OFF_DATA), {24'h0, pTx});
      rd(32'(`OFF_STATUS), {31'h0, i[2]});
      wr(32'(`OFF_PINS), 32'h1D);
      cntClr <= 1'b1;
    end
    // Disabled controller makes no clock
    idleLvl <= 1'b0;
    wr(32'(`OFF_STATUS), 32'h0);
    wr(32'(`OFF_CTRL), 32'h10);
    cntClr <= 1'b0;
    wr(32'(`OFF_DATA), 32'h5A);
    repeat (40) @(posedge core_clk);
    check("sck idle", 32'h0, 32'(actCnt));
    rd(32'(`OFF_STATUS), 32'h0);
    // Another master pulls select low
    wr(32'(`OFF_CTRL), 32'hD0);
    wr(32'(`OFF_PINS), 32'h05);
    globalIrqEnable <= 1'b1;
    tbSs <= 1'b0;
    repeat (6) @(posedge core_clk);
    check("sck drive off", 32'h1, {31'h0, sckOeN});
    check("mosi drive off", 32'h1, {31'h0, mosiOeN});
    check("irq raised", 32'h1, {31'h0, irqReq});
    rd(32'(`OFF_CTRL), 32'hC0);
    rd(32'(`OFF_STATUS), 32'h80);
    globalIrqEnable <= 1'b0;
    @(posedge core_clk);
    check("irq masked", 32'h0, {31'h0, irqReq});
    globalIrqEnable <= 1'b1;
    irqAck <= 1'b1;
    @(posedge core_clk);
    irqAck <= 1'b0;
    @(posedge core_clk);
    check("irq acked", 32'h0, {31'h0, irqReq});
    rd(32'(`OFF_STATUS), 32'h0);
    // Slave pin directions follow select
    wr(32'(`OFF_PINS), 32'h0A);
    repeat (4) @(posedge core_clk);
    check("ss drive off", 32'h1, {31'h0, ssOeN});
    check("miso driven", 32'h0, {31'h0, misoOeN});
    tbSs <= 1'b1;
    repeat (4) @(posedge core_clk);
    check("miso released", 32'h1, {31'h0, misoOeN});
    // Master again, select as plain output
    wr(32'(`OFF_CTRL), 32'hD0);
    wr(32'(`OFF_PINS), 32'h1A);
    repeat (2) @(posedge core_clk);
    check("ss out", 32'h1, {31'h0, ssOut});
    rd(32'(`OFF_CTRL), 32'hD0);
    final_report();
  end
endmodule
